// ===== src/pulse_timing_pkg.sv
// Constants, types and helpers for the pulse trigger and delay timing block
// What this block does
// - A rising start edge launches one current pulse of the programmed width.
// - Start edges launch pulses only in edge started pulse mode.
// - Each edge started pulse waits an input delay of 20 us to 1 s.
// - Marker output active only with output enabled and a pulse mode chosen.
// - Marker starts a set delay, 0 to 1 s, after the pulse rises.
// - Pulse state monitor copies the pulse, only in free running or long mode.
// - Monitor pulse is stretched four microseconds past the pulse state.
// - A start edge arriving sooner than 1 ms after the last accepted one is ignored.
// - A generated pulse gets its marker pulse only if the next pulse starts after its marker delay ends.
// - Long pulse mode takes widths from 1 ms to 2 s.
package pulse_timing_pkg;

  // Clock and microsecond tick
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = (TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam int TICK_W        = 7;

  // Monitor stretch, counted in clock cycles for precision
  localparam int STRETCH_NS     = 4000;
  localparam int STRETCH_CYCLES = (STRETCH_NS * 1000) / CLK_PERIOD_PS;
  localparam int STRETCH_W      = 10;

  // Microsecond settings and limits
  localparam int              US_W              = 21;
  localparam logic [US_W-1:0] IN_DELAY_MIN_US   = 21'h000014;
  localparam logic [US_W-1:0] DELAY_MAX_US      = 21'h0F4240;
  localparam logic [US_W-1:0] LONG_WIDTH_MIN_US = 21'h0003E8;
  localparam logic [US_W-1:0] LONG_WIDTH_MAX_US = 21'h1E8480;
  localparam logic [US_W-1:0] MIN_EDGE_GAP_US   = 21'h0003E8;
  localparam logic [US_W-1:0] MARKER_WIDTH_US   = 21'h00000A;
  localparam logic [US_W-1:0] ONE_US            = 21'h000001;

  typedef enum logic [1:0] {
    CW_MODE                 = 2'h0,
    FREE_RUNNING_PULSE_MODE = 2'h1,
    EDGE_STARTED_PULSE_MODE = 2'h2,
    LONG_PULSE_MODE         = 2'h3
  } mode_t;

  // Gray along idle, delay, high, gap
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_DELAY = 2'h1,
    ST_HIGH  = 2'h3,
    ST_GAP   = 2'h2
  } state_t;

  typedef struct packed {
    mode_t           mode;
    logic            output_enable;
    logic [US_W-1:0] pulse_width_us;
    logic [US_W-1:0] pulse_period_us;
    logic [US_W-1:0] input_delay_setting;
    logic [US_W-1:0] marker_delay_setting;
  } cfg_t;

  // Limit a microsecond value to a range
  function automatic logic [US_W-1:0] clamp_us(input logic [US_W-1:0] v, input logic [US_W-1:0] lo,
                                               input logic [US_W-1:0] hi);
    clamp_us = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_us

endpackage : pulse_timing_pkg

// ===== src/pulse_trigger_delay_timing.sv
// Pulse launch, input delay, marker and monitor timing
`timescale 1ns/1ps
module pulse_trigger_delay_timing (
  // Clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       RST_N,
  // Settings and start input
  input  wire pulse_timing_pkg::cfg_t     CFG,
  input  wire logic                       TRIG_IN,
  // Outputs
  output logic                            PULSE_OUT,
  output logic                            MARKER_OUT,
  output logic                            MONITOR_OUT
);

  localparam int W = pulse_timing_pkg::US_W;

  logic [pulse_timing_pkg::TICK_W-1:0]    tick_cnt_reg;
  logic                                   tick_reg;
  logic                                   trig_d_reg;
  logic [W-1:0]                           lock_reg;
  pulse_timing_pkg::state_t               state_reg;
  pulse_timing_pkg::state_t               state_next;
  logic [W-1:0]                           cnt_reg;
  logic [W-1:0]                           cnt_next;
  logic                                   mk_pend_reg;
  logic [W-1:0]                           mk_dly_reg;
  logic [W-1:0]                           mk_wid_reg;
  logic [pulse_timing_pkg::STRETCH_W-1:0] str_reg;

  // Mode decode
  wire en_w        = CFG.output_enable;
  wire pulse_mode_w = CFG.mode != pulse_timing_pkg::CW_MODE;
  wire trig_mode_w = CFG.mode == pulse_timing_pkg::EDGE_STARTED_PULSE_MODE;
  wire long_mode_w = CFG.mode == pulse_timing_pkg::LONG_PULSE_MODE;
  wire mon_mode_w  = long_mode_w || CFG.mode == pulse_timing_pkg::FREE_RUNNING_PULSE_MODE;
  wire run_w       = en_w && pulse_mode_w;

  // Edge qualification; inputs already synchronous to REF_CLK
  wire rise_w    = TRIG_IN && !trig_d_reg;
  wire lock_ok_w = lock_reg >= pulse_timing_pkg::MIN_EDGE_GAP_US;
  wire accept_w  = run_w && trig_mode_w && rise_w && lock_ok_w && state_reg == pulse_timing_pkg::ST_IDLE;

  // Effective timing values
  wire [W-1:0] width_w  = long_mode_w ? pulse_timing_pkg::clamp_us(CFG.pulse_width_us,
                            pulse_timing_pkg::LONG_WIDTH_MIN_US, pulse_timing_pkg::LONG_WIDTH_MAX_US)
                          : pulse_timing_pkg::clamp_us(CFG.pulse_width_us, pulse_timing_pkg::ONE_US,
                            pulse_timing_pkg::LONG_WIDTH_MAX_US);
  wire [W-1:0] gap_w    = (CFG.pulse_period_us > width_w) ? W'(CFG.pulse_period_us - width_w)
                          : pulse_timing_pkg::ONE_US;
  wire [W-1:0] in_dly_w = pulse_timing_pkg::clamp_us(CFG.input_delay_setting,
                            pulse_timing_pkg::IN_DELAY_MIN_US, pulse_timing_pkg::DELAY_MAX_US);
  wire [W-1:0] mk_dly_w = pulse_timing_pkg::clamp_us(CFG.marker_delay_setting, '0,
                            pulse_timing_pkg::DELAY_MAX_US);
  wire         expire_w = tick_reg && cnt_reg <= pulse_timing_pkg::ONE_US;
  wire [W-1:0] cnt_dec_w = tick_reg ? W'(cnt_reg - pulse_timing_pkg::ONE_US) : cnt_reg;

  // Microsecond tick from the 125 MHz clock
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= tick_cnt_reg == pulse_timing_pkg::TICK_W'(pulse_timing_pkg::TICK_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == pulse_timing_pkg::TICK_W'(pulse_timing_pkg::TICK_CYCLES - 1)) ? '0
                      : pulse_timing_pkg::TICK_W'(tick_cnt_reg + 1'b1);
    end
  end

  // Edge history and 1 ms lockout since last accepted edge
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      trig_d_reg <= 1'b1;
      lock_reg   <= pulse_timing_pkg::MIN_EDGE_GAP_US;
    end else begin
      trig_d_reg <= TRIG_IN;
      if (accept_w)
        lock_reg <= '0;
      else if (tick_reg && !lock_ok_w)
        lock_reg <= W'(lock_reg + pulse_timing_pkg::ONE_US);
    end
  end

  // Pulse sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_dec_w;
    unique case (state_reg)
      pulse_timing_pkg::ST_IDLE: begin
        cnt_next = cnt_reg;
        if (accept_w) begin
          state_next = pulse_timing_pkg::ST_DELAY;
          cnt_next   = in_dly_w;
        end else if (run_w && mon_mode_w) begin
          state_next = pulse_timing_pkg::ST_HIGH;
          cnt_next   = width_w;
        end
      end
      pulse_timing_pkg::ST_DELAY: begin
        if (expire_w) begin
          state_next = pulse_timing_pkg::ST_HIGH;
          cnt_next   = width_w;
        end
      end
      pulse_timing_pkg::ST_HIGH: begin
        if (expire_w) begin
          state_next = trig_mode_w ? pulse_timing_pkg::ST_IDLE : pulse_timing_pkg::ST_GAP;
          cnt_next   = gap_w;
        end
      end
      pulse_timing_pkg::ST_GAP: begin
        if (trig_mode_w) begin
          state_next = pulse_timing_pkg::ST_IDLE;
        end else if (expire_w) begin
          state_next = pulse_timing_pkg::ST_HIGH;
          cnt_next   = width_w;
        end
      end
    endcase
    // Disable or CW drops any pulse at once; safety beats pulse integrity
    if (!run_w) begin
      state_next = pulse_timing_pkg::ST_IDLE;
      cnt_next   = '0;
    end
  end

  wire pulse_next_w  = state_next == pulse_timing_pkg::ST_HIGH;
  wire pulse_start_w = pulse_next_w && !PULSE_OUT;
  wire pulse_end_w   = PULSE_OUT && !pulse_next_w;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_reg <= pulse_timing_pkg::ST_IDLE;
      cnt_reg   <= '0;
      PULSE_OUT <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      PULSE_OUT <= pulse_next_w;
    end
  end

  // Marker: delay from pulse rise, then a fixed width; reloaded by each pulse
  // Fire on the tick that ends the last delay microsecond, so a setting of n gives n us, not n+1
  wire         mk_fire_w    = mk_pend_reg && (mk_dly_reg == '0 ||
                              (tick_reg && mk_dly_reg == pulse_timing_pkg::ONE_US));
  wire [W-1:0] mk_wid_dec_w = (tick_reg && mk_wid_reg != '0) ? W'(mk_wid_reg - pulse_timing_pkg::ONE_US) : mk_wid_reg;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      mk_pend_reg <= 1'b0;
      mk_dly_reg  <= '0;
      mk_wid_reg  <= '0;
      MARKER_OUT  <= 1'b0;
    end else begin
      if (!run_w) begin
        mk_pend_reg <= 1'b0;
        mk_wid_reg  <= '0;
      end else if (pulse_start_w) begin
        mk_pend_reg <= 1'b1;
        mk_dly_reg  <= mk_dly_w;
      end else if (mk_fire_w) begin
        mk_pend_reg <= 1'b0;
        mk_wid_reg  <= pulse_timing_pkg::MARKER_WIDTH_US;
      end else begin
        if (mk_pend_reg && tick_reg)
          mk_dly_reg <= W'(mk_dly_reg - pulse_timing_pkg::ONE_US);
        mk_wid_reg <= mk_wid_dec_w;
      end
      MARKER_OUT <= run_w && (mk_fire_w || mk_wid_dec_w != '0);
    end
  end

  // Monitor stretch held in clock cycles, so the 4 us is exact
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      str_reg     <= '0;
      MONITOR_OUT <= 1'b0;
    end else begin
      if (pulse_end_w)
        str_reg <= pulse_timing_pkg::STRETCH_W'(pulse_timing_pkg::STRETCH_CYCLES);
      else if (str_reg != '0)
        str_reg <= pulse_timing_pkg::STRETCH_W'(str_reg - 1'b1);
      MONITOR_OUT <= mon_mode_w && (pulse_next_w || pulse_end_w || str_reg > 1);
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_edge_pulse_after_delay;
    $rose(PULSE_OUT) && trig_mode_w |-> $past(state_reg) == pulse_timing_pkg::ST_DELAY;
  endproperty
  a_edge_pulse_after_delay: assert property (p_edge_pulse_after_delay) else $error("edge pulse without delay");

  property p_delay_only_edge_mode;
    state_reg == pulse_timing_pkg::ST_IDLE && !trig_mode_w |=> state_reg != pulse_timing_pkg::ST_DELAY;
  endproperty
  a_delay_only_edge_mode: assert property (p_delay_only_edge_mode) else $error("delay outside edge mode");

  property p_input_delay_min;
    accept_w |=> state_reg == pulse_timing_pkg::ST_DELAY && cnt_reg >= pulse_timing_pkg::IN_DELAY_MIN_US;
  endproperty
  a_input_delay_min: assert property (p_input_delay_min) else $error("input delay below minimum");

  property p_marker_gated;
    !run_w |=> !MARKER_OUT;
  endproperty
  a_marker_gated: assert property (p_marker_gated) else $error("marker while not running");

  property p_marker_armed;
    pulse_start_w && run_w |=> mk_pend_reg && mk_dly_reg == $past(mk_dly_w);
  endproperty
  a_marker_armed: assert property (p_marker_armed) else $error("marker not armed by pulse");

  property p_monitor_mode;
    !mon_mode_w |=> !MONITOR_OUT;
  endproperty
  a_monitor_mode: assert property (p_monitor_mode) else $error("monitor active in wrong mode");

  property p_monitor_stretch;
    $fell(PULSE_OUT) && mon_mode_w ##1 mon_mode_w[*8] |-> MONITOR_OUT[*8];
  endproperty
  a_monitor_stretch: assert property (p_monitor_stretch) else $error("monitor not stretched");

  property p_lockout;
    accept_w |=> !lock_ok_w && lock_reg == '0;
  endproperty
  a_lockout: assert property (p_lockout) else $error("edge lockout not started");

  property p_long_width;
    $rose(PULSE_OUT) && long_mode_w |-> cnt_reg >= pulse_timing_pkg::LONG_WIDTH_MIN_US;
  endproperty
  a_long_width: assert property (p_long_width) else $error("long pulse width below minimum");

  property p_tick_spacing;
    tick_reg |=> !tick_reg[*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

  c_edge_accept:    cover property (accept_w ##[1:1000] $rose(PULSE_OUT));
  c_marker_fires:   cover property ($rose(PULSE_OUT) ##[1:1000] $rose(MARKER_OUT));
  c_edge_ignored:   cover property (rise_w && !lock_ok_w && trig_mode_w);
  c_monitor_tail:   cover property ($fell(PULSE_OUT) && MONITOR_OUT);

endmodule : pulse_trigger_delay_timing

// ===== dv/trig_instrument.sv
// Outside instrument model that drives the external start line
`timescale 1ns/1ps
module trig_instrument (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Request from the bench
  input  wire logic       fire,
  input  wire logic [7:0] high_cycles,
  // Start line to the device
  output logic            trig_out
);
  logic [7:0] cnt_reg;

  // One rising edge per request, so the edge rate sets the pulse rate
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trig_out <= 1'b0;
      cnt_reg  <= 8'h00;
    end else if (fire) begin
      trig_out <= 1'b1;
      cnt_reg  <= high_cycles;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end else begin
      trig_out <= 1'b0;
    end
  end
endmodule : trig_instrument

// ===== dv/pulse_trigger_delay_timing_tb.sv
// Self-checking bench for the pulse trigger and delay timing block
`timescale 1ns/1ps
module pulse_trigger_delay_timing_tb;
  typedef struct {int lo; int hi; int wlo; int whi;} note_t;
  logic                    ref_clk;
  logic                    rst_n;
  logic                    fire;
  logic                    trig;
  logic                    pulse;
  logic                    marker;
  logic                    monitor;
  pulse_timing_pkg::cfg_t  cfg;
  note_t                   notes[$];
  note_t                   cur;
  int                      cnt[4];
  int                      base[4];
  int                      t_cnt, p_cnt, f_cnt, mk_lo, mk_hi, d, w, m;
  int                      miscompares, comparisons;
  logic                    free_run, trig_q, pul_q, mk_q, mon_q;

  // Device and outside instrument
  pulse_trigger_delay_timing u_pulse_trigger_delay_timing (.REF_CLK(ref_clk), .RST_N(rst_n), .CFG(cfg),
    .TRIG_IN(trig), .PULSE_OUT(pulse), .MARKER_OUT(marker), .MONITOR_OUT(monitor));
  trig_instrument u_trig_instrument (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .high_cycles(8'h05),
    .trig_out(trig));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk_rng(input string name, input int lo, input int hi, input int seen);
    comparisons++;
    if (seen < lo || seen > hi) begin
      miscompares++;
      $display("unexpected %s: expected %0d..%0d seen %0d", name, lo, hi, seen);
    end
  endtask : chk_rng

  task automatic chk_bits(input string name, input logic [2:0] exp, input logic [2:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", name, exp, seen);
    end
  endtask : chk_bits

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic set_cfg(input pulse_timing_pkg::mode_t mo, input logic en, input logic [20:0] wi,
                         input logic [20:0] dl, input logic [20:0] mk);
    cfg <= '{mo, en, wi, 21'h00001E, dl, mk};
    mk_lo = (mk == 21'h0) ? 0 : (int'(mk) - 1) * 125;
    mk_hi = (mk == 21'h0) ? 127 : int'(mk) * 125 + 3;
  endtask : set_cfg

  // Bounded wait for an event count, with the marker settled low
  task automatic wait_cnt(input int idx, input int target);
    int n;
    for (n = 0; n < 20000 && !(cnt[idx] >= target && marker === 1'b0); n++) @(posedge ref_clk);
    if (n == 20000) begin
      chk_rng("wait bound", 0, 0, 1);
      summarize();
    end
  endtask : wait_cnt

  task automatic shoot();
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask : shoot

  // Watcher: samples settled outputs and checks pulse delay and width against the oldest note, marker and monitor against their own limits
  always @(negedge ref_clk) begin
    t_cnt = (trig === 1'b1 && trig_q === 1'b0) ? 0 : t_cnt + 1;
    p_cnt++;
    f_cnt++;
    if (pulse === 1'b1 && pul_q === 1'b0) begin
      cnt[0]++;
      p_cnt = 0;
      if (!free_run && notes.size() == 0) chk_rng("pulse without edge", 0, 0, 1);
      if (!free_run && notes.size() != 0) begin
        cur = notes.pop_front();
        chk_rng("start delay", cur.lo, cur.hi, t_cnt);
      end
    end
    if (pulse === 1'b0 && pul_q === 1'b1) begin
      f_cnt = 0;
      if (!free_run) chk_rng("pulse width", cur.wlo, cur.whi, p_cnt);
    end
    if (marker === 1'b1 && mk_q === 1'b0) begin
      cnt[1]++;
      chk_rng("marker delay", mk_lo, mk_hi, p_cnt);
    end
    if (monitor === 1'b1 && mon_q === 1'b0) cnt[2]++;
    if (monitor === 1'b0 && mon_q === 1'b1) begin
      cnt[3]++;
      chk_rng("monitor stretch", 4 * 125, 4 * 125, f_cnt);
    end
    {trig_q, pul_q, mk_q, mon_q} = {trig, pulse, marker, monitor};
  end

  // Main sequence
  initial begin
    {rst_n, fire, free_run, trig_q, pul_q, mk_q, mon_q} = 7'h00;
    cfg = '0;
    void'($urandom(32'h0EEB6BFE));
    repeat (10) @(negedge ref_clk) chk_bits("outputs in reset", 3'h0, {pulse, marker, monitor});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    // Start edges in CW mode launch nothing
    set_cfg(pulse_timing_pkg::CW_MODE, 1'b1, 21'h00000A, 21'h000014, 21'h000000);
    shoot();
    repeat (6000) @(posedge ref_clk);
    chk_rng("pulses in cw", 0, 0, cnt[0]);
    chk_rng("markers in cw", 0, 0, cnt[1]);
    $display("test cw_refuse done");
    // Edge started pulse with random delays
    d = 20 + $urandom % 21;
    w = 5 + $urandom % 20;
    m = $urandom % 8;
    set_cfg(pulse_timing_pkg::EDGE_STARTED_PULSE_MODE, 1'b1, 21'(w), 21'(d), 21'(m));
    notes.push_back('{(d - 1) * 125, d * 125 + 4, (w - 1) * 125, w * 125 + 2});
    shoot();
    wait_cnt(1, 1);
    chk_rng("edge pulses", 1, 1, cnt[0]);
    $display("test edge_start done");
    // A second edge well inside the lockout is dropped
    shoot();
    repeat (6000) @(posedge ref_clk);
    chk_rng("pulses after early edge", 1, 1, cnt[0]);
    chk_rng("monitor in edge mode", 0, 0, cnt[2]);
    $display("test lockout done");
    // Free running pulses, one marker each, stretched monitor
    free_run = 1'b1;
    base = cnt;
    set_cfg(pulse_timing_pkg::FREE_RUNNING_PULSE_MODE, 1'b1, 21'h00000A, 21'h000014, 21'h000000);
    wait_cnt(3, base[3] + 3);
    cfg.output_enable <= 1'b0;
    @(posedge ref_clk);
    chk_rng("markers per pulse", cnt[0] - base[0], cnt[0] - base[0], cnt[1] - base[1]);
    chk_rng("monitor per pulse", cnt[0] - base[0], cnt[0] - base[0], cnt[2] - base[2]);
    $display("test free_run done");
    // Long mode lifts a 10 us width to the 1 ms floor, so the pulse still stands after 50 us
    set_cfg(pulse_timing_pkg::LONG_PULSE_MODE, 1'b1, 21'h00000A, 21'h000014, 21'h000000);
    repeat (6250) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bits("long pulse held", 3'h5, {pulse, marker, monitor});
    @(posedge ref_clk);
    cfg.output_enable <= 1'b0;
    $display("test long_pulse done");
    // Output disabled: no pulse and no marker
    base = cnt;
    repeat (5000) @(posedge ref_clk);
    chk_rng("markers when disabled", base[1], base[1], cnt[1]);
    chk_rng("pulses when disabled", base[0], base[0], cnt[0]);
    $display("test disabled done");
    summarize();
  end
endmodule : pulse_trigger_delay_timing_tb
